// file: core/pcd_pkg.sv
// constants and types shared by the power-check and door-lock command block
// Summary of operation
// RQ1: host loads parameters, then writes command
// RQ2: BSY or DRQ set within 400 ns
// RQ3: some PIO data-out: DRQ within 700 ns
// RQ4: host zeroes unused command block bits
// RQ5: valid status at end; error if ERR
// RQ6: accept legacy power codes 94h-99h too
// RQ7: 98h and E5h query power; abort unsupported
// RQ8: standby query: BSY, count 00h, INTRQ
// RQ9: idle query: BSY, count 80h/FFh, INTRQ
// RQ10: active query: BSY, count FFh, INTRQ
// RQ11: host issues these only with DRDY set
// RQ12: lock when unlocked: lock, no error
// RQ13: lock when locked: report button, MCR+ERR
// RQ14: not ready or cannot lock: ABRT+ERR
// RQ15: while locked button only flags MCR
// RQ16: unlock, eject, or reset release lock
// RQ17: DFh unlocks and re-enables button
// RQ18: host sets Device/Head bits 7,5; bit4 selects
// RQ19: INTRQ on every lock command completion
// RQ20: BSY7 DRQ3 ERR0; MCR3 ABRT2 bit positions
package pcd_pkg;
    // command codes
    localparam logic [7:0] CMD_QUERY_NEW = 8'he5;
    localparam logic [7:0] CMD_QUERY_OLD = 8'h98;
    localparam logic [7:0] CMD_LOCK = 8'hde;
    localparam logic [7:0] CMD_UNLOCK = 8'hdf;
    localparam logic [7:0] CMD_EJECT = 8'hed;
    localparam logic [7:0] CMD_LEGACY_LO = 8'h94;
    localparam logic [7:0] CMD_LEGACY_HI = 8'h99;
    localparam logic [7:0] CMD_PM_LO = 8'he0;
    localparam logic [7:0] CMD_PM_HI = 8'he6;
    // power mode answers
    localparam logic [7:0] CNT_STANDBY = 8'h00;
    localparam logic [7:0] CNT_IDLE = 8'h80;
    localparam logic [7:0] CNT_ACTIVE = 8'hff;
    // status and error bit positions
    localparam int ST_BSY = 7;
    localparam int ST_DRDY = 6;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    localparam int ER_MCR = 3;
    localparam int ER_ABRT = 2;
    // register offsets on the plain port
    localparam logic [2:0] OFS_ERROR = 3'h1;
    localparam logic [2:0] OFS_COUNT = 3'h2;
    localparam logic [2:0] OFS_DEVHEAD = 3'h6;
    localparam logic [2:0] OFS_STATUS_CMD = 3'h7;
    localparam logic [2:0] OFS_CTRL = 3'h0;
    // reset values
    localparam logic [7:0] RST_COUNT = 8'h01;
    localparam logic [7:0] RST_DEVHEAD = 8'h00;
    // timing
    localparam int CLK_MHZ = 200;
    localparam int BSY_MAX_NS = 400;
    localparam int DRQ_MAX_NS = 700;
    localparam int BSY_MAX_CYC = BSY_MAX_NS * CLK_MHZ / 1000;
    localparam int DRQ_MAX_CYC = DRQ_MAX_NS * CLK_MHZ / 1000;
    localparam int EXEC_CYC = 4;
    // power modes
    localparam logic [1:0] PM_ACTIVE = 2'h0;
    localparam logic [1:0] PM_IDLE = 2'h1;
    localparam logic [1:0] PM_STANDBY = 2'h2;
    typedef enum logic [1:0] {PCD_IDLE, PCD_BUSY, PCD_DONE} pcd_state_e;
endpackage

// file: core/pcd_sync.sv
// two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module pcd_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// file: core/pcd_core.sv
// task-file command acceptance for power-mode query and media lock commands
`timescale 1ns/1ps
module pcd_core #(
    parameter bit PM_SUPPORTED = 1'b1,
    parameter bit LOCK_CAPABLE = 1'b1,
    parameter bit IDLE_REPORTS_FF = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // device context (pins)
    input wire logic [1:0] power_mode,
    input wire logic mcr_button,
    input wire logic dev_ready,
    // outputs
    output logic intrq,
    output logic media_locked,
    output logic eject_request
);
    logic [1:0] pm_s;
    logic button_s;
    logic ready_s;
    logic [7:0] count_r;
    logic [7:0] devhead_r;
    logic [7:0] error_r;
    logic bsy_r;
    logic err_r;
    logic drdy_r;
    logic lock_r;
    logic intrq_r;
    logic intrq_en_r;
    logic eject_r;
    logic [7:0] cmd_r;
    logic [3:0] cnt_r;
    logic [7:0] rdata_r;
    logic button_d_r;
    logic mine;
    logic cmd_wr;
    logic [7:0] status;
    pcd_pkg::pcd_state_e state_r;

    pcd_sync #(.W(4)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({power_mode, mcr_button, dev_ready}),
        .q({pm_s, button_s, ready_s})
    );

    // device select bit 4 compared with our position (device 0)
    assign mine = (devhead_r[4] == 1'b0);
    // command writes while busy are ignored so a running command is not disturbed
    assign cmd_wr = reg_wr && reg_addr == pcd_pkg::OFS_STATUS_CMD && mine && !bsy_r;

    always_comb begin
        status = 8'h00;
        status[pcd_pkg::ST_BSY] = bsy_r; // RQ20
        status[pcd_pkg::ST_DRDY] = drdy_r;
        // no data-out commands here, so DRQ never rises
        status[pcd_pkg::ST_DRQ] = 1'b0; // RQ20 RQ3
        status[pcd_pkg::ST_ERR] = err_r; // RQ20
    end

    // parameter registers loaded before the command
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            devhead_r <= pcd_pkg::RST_DEVHEAD;
        end else if (reg_wr && reg_addr == pcd_pkg::OFS_DEVHEAD) begin
            devhead_r <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drdy_r <= 1'b0;
        end else begin
            drdy_r <= ready_s;
        end
    end

    // command sequencer: accept, hold BSY, then finish
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= pcd_pkg::PCD_IDLE;
            bsy_r <= 1'b0;
            cmd_r <= 8'h00;
            cnt_r <= 4'h0;
        end else begin
            unique case (state_r)
                pcd_pkg::PCD_IDLE: begin
                    if (cmd_wr) begin
                        // BSY rises the cycle after receipt, well inside the limit
                        bsy_r <= 1'b1; // RQ2
                        cmd_r <= reg_wdata;
                        cnt_r <= 4'(pcd_pkg::EXEC_CYC);
                        state_r <= pcd_pkg::PCD_BUSY;
                    end
                end
                pcd_pkg::PCD_BUSY: begin
                    if (cnt_r == 4'h0) begin
                        state_r <= pcd_pkg::PCD_DONE;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                pcd_pkg::PCD_DONE: begin
                    bsy_r <= 1'b0; // RQ8
                    state_r <= pcd_pkg::PCD_IDLE;
                end
            endcase
        end
    end

    function automatic logic is_query(input logic [7:0] c);
        is_query = (c == pcd_pkg::CMD_QUERY_NEW) || (c == pcd_pkg::CMD_QUERY_OLD); // RQ7
    endfunction

    function automatic logic is_power(input logic [7:0] c);
        is_power = (c >= pcd_pkg::CMD_LEGACY_LO && c <= pcd_pkg::CMD_LEGACY_HI) ||
            (c >= pcd_pkg::CMD_PM_LO && c <= pcd_pkg::CMD_PM_HI && c != 8'he4); // RQ6
    endfunction

    // results are posted in the DONE cycle, together with BSY falling
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= pcd_pkg::RST_COUNT;
            error_r <= 8'h00;
            err_r <= 1'b0;
            lock_r <= 1'b0;
            eject_r <= 1'b0;
        end else if (state_r == pcd_pkg::PCD_DONE) begin
            error_r <= 8'h00; // RQ5
            err_r <= 1'b0;
            eject_r <= 1'b0;
            if (!drdy_r) begin
                error_r[pcd_pkg::ER_ABRT] <= 1'b1; // RQ14
                err_r <= 1'b1;
            end else if (is_query(cmd_r)) begin
                if (!PM_SUPPORTED) begin
                    error_r[pcd_pkg::ER_ABRT] <= 1'b1; // RQ7
                    err_r <= 1'b1;
                end else if (pm_s == pcd_pkg::PM_STANDBY) begin
                    count_r <= pcd_pkg::CNT_STANDBY; // RQ8
                end else if (pm_s == pcd_pkg::PM_IDLE) begin
                    count_r <= IDLE_REPORTS_FF ? pcd_pkg::CNT_ACTIVE : pcd_pkg::CNT_IDLE; // RQ9
                end else begin
                    count_r <= pcd_pkg::CNT_ACTIVE; // RQ10
                end
            end else if (cmd_r == pcd_pkg::CMD_LOCK) begin
                if (!LOCK_CAPABLE) begin
                    error_r[pcd_pkg::ER_ABRT] <= 1'b1; // RQ14
                    err_r <= 1'b1;
                end else if (!lock_r) begin
                    lock_r <= 1'b1; // RQ12
                end else if (button_s) begin
                    error_r[pcd_pkg::ER_MCR] <= 1'b1; // RQ13
                    err_r <= 1'b1;
                end
            end else if (cmd_r == pcd_pkg::CMD_UNLOCK) begin
                lock_r <= 1'b0; // RQ17
            end else if (cmd_r == pcd_pkg::CMD_EJECT) begin
                lock_r <= 1'b0; // RQ16
                eject_r <= 1'b1;
            end else if (!is_power(cmd_r)) begin
                error_r[pcd_pkg::ER_ABRT] <= 1'b1;
                err_r <= 1'b1;
            end
        end else begin
            // eject is a single-cycle request, not a level
            eject_r <= 1'b0;
            if (reg_wr && reg_addr == pcd_pkg::OFS_COUNT) begin
                count_r <= reg_wdata;
            end
        end
    end

    // unlocked: a button press asks for eject; locked: ignored until a lock query
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            button_d_r <= 1'b0;
        end else begin
            button_d_r <= button_s;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            media_locked <= 1'b0;
            eject_request <= 1'b0;
        end else begin
            media_locked <= lock_r;
            eject_request <= eject_r || (!lock_r && button_s && !button_d_r); // RQ15
        end
    end

    // interrupt raised at completion, cleared by status read or new command
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            intrq_r <= 1'b0;
            intrq_en_r <= 1'b1;
        end else begin
            if (reg_wr && reg_addr == pcd_pkg::OFS_CTRL) begin
                intrq_en_r <= !reg_wdata[1];
            end
            if (state_r == pcd_pkg::PCD_DONE) begin
                intrq_r <= 1'b1; // RQ19
            end else if (cmd_wr || (reg_rd && reg_addr == pcd_pkg::OFS_STATUS_CMD)) begin
                intrq_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            intrq <= 1'b0;
        end else begin
            intrq <= intrq_r && intrq_en_r && mine;
        end
    end

    // read data stand the cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                pcd_pkg::OFS_ERROR: rdata_r <= error_r;
                pcd_pkg::OFS_COUNT: rdata_r <= count_r;
                pcd_pkg::OFS_DEVHEAD: rdata_r <= devhead_r;
                pcd_pkg::OFS_STATUS_CMD: rdata_r <= status;
                default: rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign reg_rdata = rdata_r;
endmodule

// file: sim/pcd_props.sv
// assertions on the ports of the command block
`timescale 1ns/1ps
module pcd_props (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // pins
    input wire logic dev_ready,
    input wire logic intrq,
    input wire logic media_locked,
    input wire logic eject_request
);
    logic dev1_r;
    logic [2:0] bcnt_r;
    logic acc;
    logic ien_r;
    // a command is taken only for device 0 while not busy; busy is over once the count is at one
    assign acc = reg_wr && reg_addr == 3'h7 && !dev1_r && bcnt_r < 3'h2;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ien_r <= 1'b1;
        end else if (reg_wr && reg_addr == 3'h0) begin
            ien_r <= !reg_wdata[1];
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dev1_r <= 1'b0;
        end else if (reg_wr && reg_addr == 3'h6) begin
            dev1_r <= reg_wdata[4];
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bcnt_r <= 3'h0;
        end else if (acc) begin
            bcnt_r <= 3'h7;
        end else if (bcnt_r != 3'h0) begin
            bcnt_r <= bcnt_r - 3'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ready is judged where the design's synchronised copy picks it up
    lock_on_a: assert property ((acc && reg_wdata == 8'hde) ##3 dev_ready |-> ##5 media_locked)
        else $error("lock not entered");
    unlock_a: assert property ((acc && reg_wdata == 8'hdf) ##3 dev_ready |-> ##5 !media_locked)
        else $error("unlock failed");
    eject_a: assert property ((acc && reg_wdata == 8'hed) ##3 dev_ready |-> ##5 !media_locked)
        else $error("eject kept lock");
    irq_done_a: assert property (acc && ien_r && reg_wdata inside {8'hde, 8'h98, 8'he5} |-> ##8 intrq)
        else $error("no interrupt");
    irq_early_a: assert property (acc |-> ##2 !intrq [*5])
        else $error("interrupt before done");
    bsy_set_a: assert property (reg_rd && reg_addr == 3'h7 && bcnt_r >= 3'h2 |=> reg_rdata[7])
        else $error("busy not shown");
    bsy_clear_a: assert property (reg_rd && reg_addr == 3'h7 && bcnt_r < 3'h2 |=> !reg_rdata[7])
        else $error("busy not cleared");
    lock_hold_a: assert property (media_locked && bcnt_r == 3'h0 && !acc |=> $stable(media_locked))
        else $error("lock dropped");
    button_quiet_a: assert property (media_locked && bcnt_r == 3'h0 |-> !eject_request)
        else $error("button acted while locked");
endmodule
bind pcd_core pcd_props pcd_props_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dev_ready(dev_ready), .intrq(intrq),
    .media_locked(media_locked), .eject_request(eject_request));

// file: sim/pcd_host.sv
// host adapter model issuing task-file register cycles
`timescale 1ns/1ps
module pcd_host (
    // clock
    input wire logic clk,
    // register port
    output logic [2:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        // idle bus carries no stale copy
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask
    task automatic issue(input logic dev, input logic [7:0] code);
        wr(pcd_pkg::OFS_DEVHEAD, {2'b10, 1'b1, dev, 4'h0});
        wr(pcd_pkg::OFS_STATUS_CMD, code);
    endtask
endmodule

// file: sim/test_power_check_door_lock_cmds.sv
// self-checking bench for the command block
`timescale 1ns/1ps
module test_power_check_door_lock_cmds;
    logic clk;
    logic rst_n;
    logic [1:0] power_mode;
    logic mcr_button;
    logic dev_ready;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic intrq;
    logic media_locked;
    logic eject_request;
    logic [7:0] v;
    logic ej;
    int failures;
    int total_checks;
    logic [7:0] cnt_exp [3] = '{8'hff, 8'h80, 8'h00};
    logic [7:0] ok_codes [10] = '{8'h94, 8'h95, 8'h96, 8'h97, 8'h99, 8'he0, 8'he1, 8'he2, 8'he3, 8'he6};
    pcd_core pcd_core_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_mode(power_mode),
        .mcr_button(mcr_button), .dev_ready(dev_ready), .intrq(intrq), .media_locked(media_locked),
        .eject_request(eject_request));
    pcd_host pcd_host_inst (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_is(input logic [2:0] a, input logic [7:0] exp);
        pcd_host_inst.rd(a, v);
        chk8(v, exp);
    endtask
    // interrupt is due in the eighth cycle after the command write
    task automatic cmd(input logic [7:0] code, input logic [7:0] st);
        pcd_host_inst.issue(1'b0, code);
        repeat (8) @(posedge clk);
        ej = eject_request;
        chk8({7'h0, intrq}, 8'h01);
        reg_is(pcd_pkg::OFS_STATUS_CMD, st);
    endtask
    task automatic print_verdict;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        print_verdict;
    end
    initial begin
        rst_n = 1'b0;
        power_mode = pcd_pkg::PM_ACTIVE;
        mcr_button = 1'b0;
        dev_ready = 1'b1;
        failures = 0;
        total_checks = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        reg_is(pcd_pkg::OFS_COUNT, pcd_pkg::RST_COUNT);
        for (int m = 0; m < 6; m++) begin
            power_mode <= 2'(m / 2);
            repeat (3) @(posedge clk);
            cmd(m[0] ? pcd_pkg::CMD_QUERY_OLD : pcd_pkg::CMD_QUERY_NEW, 8'h40);
            reg_is(pcd_pkg::OFS_COUNT, cnt_exp[m / 2]);
        end
        foreach (ok_codes[i]) cmd(ok_codes[i], 8'h40);
        cmd(8'he4, 8'h41);
        reg_is(pcd_pkg::OFS_ERROR, 8'h04);
        cmd(pcd_pkg::CMD_LOCK, 8'h40);
        chk8({7'h0, media_locked}, 8'h01);
        mcr_button <= 1'b1;
        repeat (6) @(posedge clk);
        cmd(pcd_pkg::CMD_LOCK, 8'h41);
        reg_is(pcd_pkg::OFS_ERROR, 8'h08);
        mcr_button <= 1'b0;
        repeat (6) @(posedge clk);
        cmd(pcd_pkg::CMD_LOCK, 8'h40);
        cmd(pcd_pkg::CMD_UNLOCK, 8'h40);
        chk8({7'h0, media_locked}, 8'h00);
        chk8({7'h0, ej}, 8'h00);
        cmd(pcd_pkg::CMD_LOCK, 8'h40);
        cmd(pcd_pkg::CMD_EJECT, 8'h40);
        chk8({7'h0, media_locked}, 8'h00);
        chk8({7'h0, ej}, 8'h01);
        // a press while unlocked asks for eject once
        mcr_button <= 1'b1;
        repeat (4) @(posedge clk);
        chk8({7'h0, eject_request}, 8'h01);
        @(posedge clk);
        mcr_button <= 1'b0;
        chk8({7'h0, eject_request}, 8'h00);
        cmd(pcd_pkg::CMD_LOCK, 8'h40);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        chk8({7'h0, media_locked}, 8'h00);
        dev_ready <= 1'b0;
        repeat (5) @(posedge clk);
        cmd(pcd_pkg::CMD_LOCK, 8'h01);
        reg_is(pcd_pkg::OFS_ERROR, 8'h04);
        dev_ready <= 1'b1;
        repeat (5) @(posedge clk);
        // interrupt masked through the control register
        pcd_host_inst.wr(pcd_pkg::OFS_CTRL, 8'h02);
        pcd_host_inst.issue(1'b0, pcd_pkg::CMD_QUERY_NEW);
        repeat (8) @(posedge clk);
        chk8({7'h0, intrq}, 8'h00);
        pcd_host_inst.wr(pcd_pkg::OFS_CTRL, 8'h00);
        reg_is(pcd_pkg::OFS_STATUS_CMD, 8'h40);
        // a command aimed at the other device must be left alone
        pcd_host_inst.issue(1'b1, pcd_pkg::CMD_LOCK);
        repeat (8) @(posedge clk);
        chk8({6'h0, intrq, media_locked}, 8'h00);
        print_verdict;
    end
endmodule
